// >>> hdl/dmbs_bit_retimer.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Each effective sampling instant captures the data bit and holds it until the next one.
// - The effective sampling rate is the sample clock divided by one, two or four per selector.
// - The overload flag rises with the third sample when it and the two before are all equal.
// - Without a run of three equal samples the overload flag stays inactive.
// - Each sampled bit appears at once as a logic-level copy and a signed two-level copy.
// - The front-end decision gives one above zero and zero below zero, with no inversion.
// - Sample clocks from 1 kHz up to 500 kHz are served.
module dmbs_bit_retimer
    import dmbs_pkg::*;
#(
    parameter int unsigned IN_W = FRONT_W
) (
    input  wire logic                   core_clk,        // Core clock, 25 MHz
    input  wire logic                   rst_n,           // Sync reset, active low
    input  wire logic signed [IN_W-1:0] front_in,        // Signed front-end level
    input  wire logic                   sample_clk_in,   // Incoming sample clock level
    input  wire logic [1:0]             div_sel,         // Divider selector
    output logic                        zero_cross_bit,  // Decision output
    output logic                        data_bit,        // Held sampled bit
    output logic signed [1:0]           bipolar_bit,     // Held signed copy
    output logic                        overload,        // Slope overload flag
    output logic                        sample_strobe,   // Pulse per sampling instant
    output logic                        strm_fill_ready, // Buffer accepts new words
    output logic                        strm_valid,      // Stream word available
    input  wire logic                   strm_ready,      // Receiver takes word
    output logic                        strm_bit,        // Stream logic bit
    output logic signed [1:0]           strm_bipolar,    // Stream signed bit
    output logic                        strm_overload    // Stream overload flag
);

    // Refuse a core clock too slow to see every edge of the fastest clock
    if (SAMPLE_MAX_CYCLES < EDGE_MIN_CYCLES)
    begin : g_rate_check
        $error("core clock too slow for the sample clock range");
    end
    if (IN_W < 2)
    begin : g_width_check
        $error("front-end width must be at least two bits");
    end
    // Stream word must hold exactly bit, signed copy and flag
    if (WORD_W != WORD_OVL + 1)
    begin : g_word_check
        $error("stream word layout does not fit its width");
    end

    // Divider terminal count decode, shared by divider and wrap guard
    function automatic logic [1:0] div_last(input logic [1:0] sel);
        logic [1:0] res;
        res = DIV4_LAST;
        if (sel == DMBS_DIV1)
        begin
            res = DIV1_LAST;
        end
        else if (sel == DMBS_DIV2)
        begin
            res = DIV2_LAST;
        end
        return res;
    endfunction : div_last

    logic              decide_ff;
    logic              nxt_decide;
    logic              clk_prev_ff;
    logic              nxt_clk_prev;
    logic [1:0]        div_cnt_ff;
    logic [1:0]        nxt_div_cnt;
    logic              strobe_ff;
    logic              nxt_strobe;
    logic              bit_ff;
    logic              nxt_bit;
    logic signed [1:0] bip_ff;
    logic signed [1:0] nxt_bip;
    logic [1:0]        run_ff;
    logic [1:0]        nxt_run;
    logic              ovl_ff;
    logic              nxt_ovl;
    logic              clk_rise;
    logic              take;
    logic [1:0]        last_cnt;
    logic [WORD_W-1:0] buf_out;

    // Threshold at the front-end width, so the compare stays signed
    localparam logic signed [IN_W-1:0] ZERO_LEVEL = '0;

    // Zero-crossing decision; exactly zero keeps the old decision
    always_comb
    begin
        nxt_decide = decide_ff;
        if (front_in > ZERO_LEVEL)
        begin
            nxt_decide = 1'b1;
        end
        else if (front_in < ZERO_LEVEL)
        begin
            nxt_decide = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            decide_ff <= 1'b0;
        end
        else
        begin
            decide_ff <= nxt_decide;
        end
    end

    // Rising edges of the sample clock, divided down per selector
    assign clk_rise = sample_clk_in && !clk_prev_ff;
    assign last_cnt = div_last(div_sel);
    // A reselect to a smaller ratio wraps at once rather than run long
    assign take     = clk_rise && (div_cnt_ff >= last_cnt);

    always_comb
    begin
        nxt_clk_prev = sample_clk_in;
        nxt_div_cnt  = div_cnt_ff;
        if (clk_rise)
        begin
            if (div_cnt_ff >= last_cnt)
            begin
                nxt_div_cnt = 2'h0;
            end
            else
            begin
                nxt_div_cnt = div_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            clk_prev_ff <= 1'b0;
            div_cnt_ff  <= 2'h0;
        end
        else
        begin
            clk_prev_ff <= nxt_clk_prev;
            div_cnt_ff  <= nxt_div_cnt;
        end
    end

    // Sample capture, run tracking and overload flag
    always_comb
    begin
        nxt_bit    = bit_ff;
        nxt_bip    = bip_ff;
        nxt_run    = run_ff;
        nxt_ovl    = ovl_ff;
        nxt_strobe = take;
        if (take)
        begin
            nxt_bit = decide_ff;
            nxt_bip = decide_ff ? BIPOLAR_POS : BIPOLAR_NEG;
            if (run_ff != RUN_RESET && decide_ff == bit_ff)
            begin
                // Saturate: three is all the flag needs
                nxt_run = (run_ff == RUN_OVERLD) ? RUN_OVERLD : run_ff + 2'h1;
            end
            else
            begin
                nxt_run = RUN_FIRST;
            end
            nxt_ovl = (nxt_run == RUN_OVERLD);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bit_ff    <= 1'b0;
            bip_ff    <= BIPOLAR_NEG;
            run_ff    <= RUN_RESET;
            ovl_ff    <= 1'b0;
            strobe_ff <= 1'b0;
        end
        else
        begin
            bit_ff    <= nxt_bit;
            bip_ff    <= nxt_bip;
            run_ff    <= nxt_run;
            ovl_ff    <= nxt_ovl;
            strobe_ff <= nxt_strobe;
        end
    end

    assign zero_cross_bit = decide_ff;
    assign data_bit       = bit_ff;
    assign bipolar_bit    = bip_ff;
    assign overload       = ovl_ff;
    assign sample_strobe  = strobe_ff;

    // Stream copy; a word enters one cycle after capture, when flops are settled
    // A strobe while both entries are full is lost; strm_fill_ready low shows it
    dmbs_buf2 #(
        .W (WORD_W)
    ) u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (strobe_ff),
        .in_ready  (strm_fill_ready),
        .in_data   ({ovl_ff, bip_ff, bit_ff}),
        .out_valid (strm_valid),
        .out_ready (strm_ready),
        .out_data  (buf_out)
    );

    assign strm_bit      = buf_out[WORD_BIT];
    assign strm_bipolar  = buf_out[WORD_BIP_HI:WORD_BIP_LO];
    assign strm_overload = buf_out[WORD_OVL];

endmodule : dmbs_bit_retimer

`default_nettype wire

// >>> hdl/dmbs_buf2.sv
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; entries are flops so read data comes from a register
module dmbs_buf2 #(
    parameter int unsigned W = 4
) (
    input  wire logic         core_clk,   // Core clock
    input  wire logic         rst_n,      // Sync reset, active low
    input  wire logic         in_valid,   // Word offered
    output logic              in_ready,   // Room for a word
    input  wire logic [W-1:0] in_data,    // Word in
    output logic              out_valid,  // Word available
    input  wire logic         out_ready,  // Receiver takes word
    output logic [W-1:0]      out_data    // Word out
);

    logic [W-1:0] mem_ff [2];
    logic [W-1:0] nxt_mem [2];
    logic         wr_ptr_ff;
    logic         nxt_wr_ptr;
    logic         rd_ptr_ff;
    logic         nxt_rd_ptr;
    logic [1:0]   cnt_ff;
    logic [1:0]   nxt_cnt;
    logic         do_wr;
    logic         do_rd;

    // Honest flags straight from the occupancy count
    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // Pointer and storage update
    always_comb
    begin
        nxt_mem    = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_cnt    = cnt_ff;
        if (do_wr)
        begin
            nxt_mem[wr_ptr_ff] = in_data;
            nxt_wr_ptr         = ~wr_ptr_ff;
        end
        if (do_rd)
        begin
            nxt_rd_ptr = ~rd_ptr_ff;
        end
        if (do_wr && !do_rd)
        begin
            nxt_cnt = cnt_ff + 2'h1;
        end
        else if (do_rd && !do_wr)
        begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end
        else
        begin
            mem_ff    <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff    <= nxt_cnt;
        end
    end

endmodule : dmbs_buf2

`default_nettype wire

// >>> hdl/dmbs_pkg.sv
package dmbs_pkg;

    // Core clock and sample clock range
    localparam int unsigned CORE_CLK_HZ        = 25_000_000;
    localparam int unsigned SAMPLE_CLK_MIN_HZ  = 1_000;
    localparam int unsigned SAMPLE_CLK_MAX_HZ  = 500_000;
    localparam int unsigned SAMPLE_CLK_NOM_HZ  = 100_000;
    // Core cycles per period of the fastest sample clock
    localparam int unsigned SAMPLE_MAX_CYCLES  = CORE_CLK_HZ / SAMPLE_CLK_MAX_HZ;
    // Core cycles per period of the nominal sample clock
    localparam int unsigned SAMPLE_NOM_CYCLES  = CORE_CLK_HZ / SAMPLE_CLK_NOM_HZ;
    // Least core cycles per sample clock period the edge detector needs
    localparam int unsigned EDGE_MIN_CYCLES    = 2;

    // Divider selector codes
    typedef enum logic [1:0] {
        DMBS_DIV1 = 2'h0,
        DMBS_DIV2 = 2'h1,
        DMBS_DIV4 = 2'h2,
        DMBS_DIVX = 2'h3
    } dmbs_div_t;

    // Terminal counts of the clock divider
    localparam logic [1:0] DIV1_LAST = 2'h0;
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    // Run length handling
    localparam logic [1:0] RUN_RESET   = 2'h0;
    localparam logic [1:0] RUN_FIRST   = 2'h1;
    localparam logic [1:0] RUN_OVERLD  = 2'h3;

    // Signed two-level output codes
    localparam logic signed [1:0] BIPOLAR_POS  = 2'sh1;
    localparam logic signed [1:0] BIPOLAR_NEG  = -2'sh1;

    // Buffer word layout
    localparam int unsigned WORD_W       = 4;
    localparam int unsigned WORD_BIT     = 0;
    localparam int unsigned WORD_BIP_LO  = 1;
    localparam int unsigned WORD_BIP_HI  = 2;
    localparam int unsigned WORD_OVL     = 3;

    // Default width of the signed front-end input
    localparam int unsigned FRONT_W = 12;

endpackage : dmbs_pkg

// >>> test/dmbs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port checker for the retimer; keeps its own record of instants and runs
module dmbs_asserts
    import dmbs_pkg::*;
#(
    parameter int unsigned IN_W = FRONT_W
) (
    input wire logic                   core_clk,        // Clock
    input wire logic                   rst_n,           // Reset
    input wire logic signed [IN_W-1:0] front_in,        // Level
    input wire logic                   sample_clk_in,   // Sample clock
    input wire logic [1:0]             div_sel,         // Divider
    input wire logic                   zero_cross_bit,  // Decision
    input wire logic                   data_bit,        // Held bit
    input wire logic signed [1:0]      bipolar_bit,     // Signed bit
    input wire logic                   overload,        // Flag
    input wire logic                   sample_strobe,   // Instant
    input wire logic                   strm_fill_ready, // Room
    input wire logic                   strm_valid       // Word
);
    logic       prev_ff, h1_ff, h2_ff, rise, inst;
    logic [1:0] cnt_ff, runs_ff, last;
    // Expected instant; code 3 divides by four
    always_comb
    begin
        last = (div_sel == DMBS_DIV1) ? DIV1_LAST : (div_sel == DMBS_DIV2) ? DIV2_LAST : DIV4_LAST;
        rise = sample_clk_in && !prev_ff;
        inst = rise && (cnt_ff >= last);
    end
    // Count starts at zero like the divider, so /N samples on the Nth rise
    always_ff @(posedge core_clk)
    begin
        prev_ff <= rst_n && sample_clk_in;
        cnt_ff  <= !rst_n ? 2'h0 : !rise ? cnt_ff : inst ? 2'h0 : cnt_ff + 2'h1;
        runs_ff <= !rst_n ? 2'h0 : (!sample_strobe || runs_ff == 2'h2) ? runs_ff : runs_ff + 2'h1;
        h1_ff   <= sample_strobe ? data_bit : h1_ff;
        h2_ff   <= sample_strobe ? h1_ff : h2_ff;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_inst;
        inst;
    endsequence
    chk_strobe_single: assert property (sample_strobe |=> !sample_strobe)
        else $error("strobe longer than one cycle");
    chk_rate_hit: assert property (s_inst |=> sample_strobe)
        else $error("instant missed");
    chk_rate_only: assert property (sample_strobe |-> $past(inst))
        else $error("strobe without instant");
    chk_capture_bit: assert property (sample_strobe |-> data_bit == $past(zero_cross_bit))
        else $error("wrong bit captured");
    chk_hold_between: assert property (!sample_strobe |-> $stable(data_bit) && $stable(overload))
        else $error("output moved between instants");
    chk_bipolar_pair: assert property (bipolar_bit == (data_bit ? BIPOLAR_POS : BIPOLAR_NEG))
        else $error("signed copy differs");
    chk_overload_run: assert property (sample_strobe |->
        overload == (runs_ff == 2'h2 && data_bit == h1_ff && h1_ff == h2_ff))
        else $error("overload flag wrong");
    chk_decide_sense: assert property (front_in > 0 |=> zero_cross_bit)
        else $error("positive level not decided high");
    chk_decide_low: assert property (front_in < 0 |=> !zero_cross_bit)
        else $error("negative level not decided low");
    chk_push_valid: assert property (sample_strobe && strm_fill_ready |=> strm_valid)
        else $error("sample not buffered");
endmodule : dmbs_asserts
bind dmbs_bit_retimer dmbs_asserts #(.IN_W(IN_W)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .front_in(front_in), .sample_clk_in(sample_clk_in),
    .div_sel(div_sel), .zero_cross_bit(zero_cross_bit), .data_bit(data_bit),
    .bipolar_bit(bipolar_bit), .overload(overload), .sample_strobe(sample_strobe),
    .strm_fill_ready(strm_fill_ready), .strm_valid(strm_valid));
`default_nettype wire

// >>> test/dmbs_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// Loop front end: offers a level and a sample clock of eight core cycles, or 250 core cycles when nominal is high
module dmbs_front_model
    import dmbs_pkg::*;
(
    input  wire logic                  core_clk,      // Clock
    input  wire logic                  run,           // Clock enable
    input  wire logic                  nominal,       // 100 kHz clock when high
    input  wire logic signed [FRONT_W-1:0] level,     // Loop level
    output logic                       sample_clk_in, // Sample clock
    output logic signed [FRONT_W-1:0]  front_in       // To decider
);
    logic [7:0] n_ff = 8'h00;
    logic [7:0] half_last;
    initial sample_clk_in = 1'h0;
    // Level goes straight into the decision
    assign front_in = level;
    // Half period: nominal rate, or four cycles to keep runs short
    assign half_last = nominal ? 8'(SAMPLE_NOM_CYCLES / 2 - 1) : 8'h03;
    // Parked low when stopped, so a restart never shows a stray rise
    always @(negedge core_clk)
    begin
        n_ff <= (!run || n_ff == half_last) ? 8'h00 : n_ff + 8'h01;
        sample_clk_in <= !run ? 1'h0 : (n_ff == half_last) ? !sample_clk_in : sample_clk_in;
    end
endmodule : dmbs_front_model
`default_nettype wire

// >>> test/tb_delta_mod_bit_bit_retimer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_delta_mod_bit_bit_retimer;
    import dmbs_pkg::*;
    logic                      core_clk, rst_n, run, nominal, strm_ready, sample_clk_in, data_bit;
    logic                      overload, sample_strobe, strm_fill_ready, strm_valid;
    logic                      strm_bit, strm_overload;
    logic [1:0]                div_sel;
    logic signed [1:0]         bipolar_bit, strm_bipolar;
    logic signed [FRONT_W-1:0] level, front_in;
    int                        failures, checked, cycles, strobes;
    logic signed [FRONT_W-1:0] lv [9] = '{12'sh7FF, 12'sh001, 12'sh005, 12'sh800, 12'sh000,
                                          12'shFFF, 12'sh001, 12'sh000, 12'sh000};
    dmbs_bit_retimer u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .front_in(front_in), .sample_clk_in(sample_clk_in),
        .div_sel(div_sel), .zero_cross_bit(), .data_bit(data_bit), .bipolar_bit(bipolar_bit),
        .overload(overload), .sample_strobe(sample_strobe), .strm_fill_ready(strm_fill_ready),
        .strm_valid(strm_valid), .strm_ready(strm_ready), .strm_bit(strm_bit),
        .strm_bipolar(strm_bipolar), .strm_overload(strm_overload));
    dmbs_front_model u_front (.core_clk(core_clk), .run(run), .nominal(nominal), .level(level),
        .sample_clk_in(sample_clk_in), .front_in(front_in));
    initial
    begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    // Strobe tally and a cycle ceiling of 5000, over three times the roughly 1500 needed
    always @(posedge core_clk)
    begin
        cycles++;
        strobes += (sample_strobe === 1'h1);
        if (cycles == 5000) failures++;
        if (cycles == 5000) test_done();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) failures++;
        if (seen !== exp) $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    endtask : check
    function automatic logic [7:0] word(input logic b, input logic o);
        return {4'h0, o, b ? BIPOLAR_POS : BIPOLAR_NEG, b};
    endfunction : word
    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    // Bounded wait for the next strobe; steps once so one strobe counts once
    task automatic wait_strobe();
        int i = 0;
        @(negedge core_clk);
        while (sample_strobe !== 1'h1 && i++ < 40) @(negedge core_clk);
        if (i > 40) failures++;
    endtask : wait_strobe
    task automatic do_reset(input logic [1:0] d);
        rst_n = 1'h0;
        div_sel = d;
        repeat (2) @(negedge core_clk);
        rst_n = 1'h1;
        strobes = 0;
    endtask : do_reset
    // Twelve sample clock rises under each selector code
    task automatic test_div();
        for (int d = 0; d < 4; d++)
        begin
            do_reset(d[1:0]);
            run <= 1'h1;
            repeat (96) @(negedge core_clk);
            run <= 1'h0;
            repeat (4) @(negedge core_clk);
            check(strobes[7:0], 8'h0C >> (d == 3 ? 2 : d));
        end
    endtask : test_div
    // Extreme and zero levels; runs of three end at samples 2, 5 and 8
    task automatic test_pattern();
        logic [8:0] eb = 9'h1C7;
        logic [8:0] eo = 9'h124;
        level = lv[0];
        do_reset(2'h0);
        strm_ready = 1'h1;
        run <= 1'h1;
        for (int i = 0; i < 9; i++)
        begin
            wait_strobe();
            check({4'h0, overload, bipolar_bit, data_bit}, word(eb[i], eo[i]));
            @(negedge core_clk);
            check({4'h0, strm_overload, strm_bipolar, strm_bit}, word(eb[i], eo[i]));
            level = lv[(i + 1) % 9];
        end
        run <= 1'h0;
    endtask : test_pattern
    // Stalled receiver: two words kept, the third dropped
    task automatic test_buffer();
        strm_ready = 1'h0;
        level = 12'sh010;
        do_reset(2'h0);
        run <= 1'h1;
        wait_strobe();
        level = 12'shFF0;
        wait_strobe();
        @(negedge core_clk);
        check({7'h0, strm_fill_ready}, 8'h00);
        level = 12'sh010;
        wait_strobe();
        run <= 1'h0;
        @(negedge core_clk);
        strm_ready = 1'h1;
        check({4'h0, strm_overload, strm_bipolar, strm_bit}, word(1'h1, 1'h0));
        @(negedge core_clk);
        check({4'h0, strm_overload, strm_bipolar, strm_bit}, word(1'h0, 1'h0));
        @(negedge core_clk);
        check({7'h0, strm_valid}, 8'h00);
    endtask : test_buffer
    // Nominal 100 kHz clock divided by two: four rises give two samples
    task automatic test_nominal();
        level = 12'sh020;
        do_reset(2'h1);
        nominal = 1'h1;
        run <= 1'h1;
        repeat (1000) @(negedge core_clk);
        run <= 1'h0;
        repeat (4) @(negedge core_clk);
        nominal = 1'h0;
        check(strobes[7:0], 8'h02);
        check({7'h0, data_bit}, 8'h01);
    endtask : test_nominal
    initial
    begin
        {rst_n, run, nominal, strm_ready, div_sel, level} = '0;
        {failures, checked, cycles, strobes} = '0;
        test_div();
        test_pattern();
        test_buffer();
        test_nominal();
        test_done();
    end
endmodule : tb_delta_mod_bit_bit_retimer
`default_nettype wire
